// ### logic/jtb_map.svh
// offsets, field positions, reset values and codes for the test access port
`ifndef JTB_MAP_SVH
`define JTB_MAP_SVH

// instruction register
`define JTB_IR_W 4
`define JTB_IR_BYPASS 4'hF
`define JTB_IR_IDCODE 4'h1
`define JTB_IR_CAPTURE 4'h1

// data registers
`define JTB_ID_W 32
`define JTB_BYP_W 1
`define JTB_BYP_CAPTURE 1'h0

// identification value, arbitrary neutral value, lsb must stay 1
`define JTB_IDCODE_DEF 32'h0A5C_3001

// pin group layout
`define JTB_PINS 4
`define JTB_PIN_TCK 0
`define JTB_PIN_TMS 1
`define JTB_PIN_TDI 2
`define JTB_PIN_TDO 3

// reset values of the pin group
`define JTB_PIN_IDLE 4'hF
`define JTB_OE_ALL_OFF 4'hF
`define JTB_PIN_OUT_RST 4'h0

`endif

// ### logic/jtb_pkg.sv
// types shared by the test access port files
`include "jtb_map.svh"

package jtb_pkg;

  // controller states, gray coded along the usual walk
  typedef enum logic [3:0] {
    JTB_TLR = 4'h0,
    JTB_RTI = 4'h1,
    JTB_SEL_DR = 4'h3,
    JTB_CAP_DR = 4'h2,
    JTB_SH_DR = 4'h6,
    JTB_EX1_DR = 4'h7,
    JTB_PAU_DR = 4'h5,
    JTB_EX2_DR = 4'h4,
    JTB_UPD_DR = 4'hC,
    JTB_SEL_IR = 4'hD,
    JTB_CAP_IR = 4'hF,
    JTB_SH_IR = 4'hE,
    JTB_EX1_IR = 4'hA,
    JTB_PAU_IR = 4'hB,
    JTB_EX2_IR = 4'h9,
    JTB_UPD_IR = 4'h8
  } jtb_tap_t;

  // the four shared pins, one bit each
  typedef logic [`JTB_PINS-1:0] jtb_pins_t;

  // whole state of the top module
  typedef struct packed {
    jtb_tap_t st;
    logic [`JTB_IR_W-1:0] ir_act;
    logic tck_d;
    logic gpio;
    jtb_pins_t pin_out;
    jtb_pins_t pin_oe_n;
    jtb_pins_t usr_in;
  } jtb_top_state_t;

endpackage

// ### logic/jtb_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps

module jtb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jtb_sync_st_t;

  jtb_sync_st_t q;
  jtb_sync_st_t d;

  // first stage feeds only the second stage
  always_comb
  begin
    d.s1 = i_d;
    d.s2 = q.s1;
  end

  // registered stages, pulled-up idle level at reset
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      q <= {RST, RST};
    end
    else
    begin
      q <= d;
    end
  end

  assign o_q = q.s2;

endmodule

// ### logic/jtb_shreg.sv
// parallel capture, serial shift register, lsb leaves first
`timescale 1ns/10ps

module jtb_shreg #(
  parameter int W = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cap,
  input wire logic i_shift,
  input wire logic [W-1:0] i_cap_val,
  input wire logic i_sin,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] sr;
  } jtb_shreg_st_t;

  jtb_shreg_st_t q;
  jtb_shreg_st_t d;
  logic [W:0] cat;

  // capture wins over shift; shift moves towards bit 0
  always_comb
  begin
    cat = {i_sin, q.sr};
    d = q;
    if (i_cap)
    begin
      d.sr = i_cap_val;
    end
    else if (i_shift)
    begin
      d.sr = cat[W:1];
    end
  end

  // state register
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_q = q.sr;

endmodule

// ### logic/jtb_tap.sv
// reduced test access port with bypass and identification, sharing pins with user i/o
//
// Operation
// R1 - all-ones instruction puts one-bit bypass register between serial input and output
// R2 - holding serial input high through an instruction scan selects bypass
// R3 - bypass shifting follows test clock and leaves user logic undisturbed
// R4 - code 0001 puts identification register between serial input and output
// R5 - no test reset pin; power-up reset resets test logic
// R6 - serial input sampled on each rising test clock edge while shifting
// R7 - serial output updated on each falling test clock edge while shifting
// R8 - serial output floats whenever nothing is shifted out
// R9 - far side keeps mode select high during normal user operation
// R10 - pins default to test function; stored option returns them to i/o
// R11 - macrocells behind test pins stay usable as buried logic
// R12 - once disabling configuration is present, four pins act as plain i/o
// R13 - standard sixteen-state controller on rising test clock, four-bit instruction
// R14 - unknown instruction codes select the bypass register
`timescale 1ns/10ps
`include "jtb_map.svh"

module jtb_tap #(
  parameter logic [`JTB_ID_W-1:0] IDCODE = `JTB_IDCODE_DEF // arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cfg_port_off,
  input wire jtb_pkg::jtb_pins_t i_pin_in,
  output jtb_pkg::jtb_pins_t o_pin_out,
  output jtb_pkg::jtb_pins_t o_pin_oe_n,
  input wire jtb_pkg::jtb_pins_t i_usr_out,
  input wire jtb_pkg::jtb_pins_t i_usr_oe_n,
  output jtb_pkg::jtb_pins_t o_usr_in,
  output logic o_port_gpio,
  output jtb_pkg::jtb_tap_t o_tap_state,
  output logic [`JTB_IR_W-1:0] o_ir
);

  import jtb_pkg::*;

  jtb_top_state_t q;
  jtb_top_state_t d;

  jtb_pins_t pin_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;
  logic sel_id;
  logic sh_ir;
  logic sh_dr;
  logic ir_cap;
  logic ir_shift;
  logic id_cap;
  logic id_shift;
  logic byp_cap;
  logic byp_shift;
  logic [`JTB_IR_W-1:0] ir_sr;
  logic [`JTB_ID_W-1:0] id_sr;
  logic [`JTB_BYP_W-1:0] byp_sr;
  logic tdo_bit;

  // controller transition on one rising test clock edge
  function automatic jtb_tap_t tap_next(input jtb_tap_t st, input logic tms);
    jtb_tap_t nx;
    nx = st;
    unique case (st)
      JTB_TLR:    nx = tms ? JTB_TLR : JTB_RTI;
      JTB_RTI:    nx = tms ? JTB_SEL_DR : JTB_RTI;
      JTB_SEL_DR: nx = tms ? JTB_SEL_IR : JTB_CAP_DR;
      JTB_CAP_DR: nx = tms ? JTB_EX1_DR : JTB_SH_DR;
      JTB_SH_DR:  nx = tms ? JTB_EX1_DR : JTB_SH_DR;
      JTB_EX1_DR: nx = tms ? JTB_UPD_DR : JTB_PAU_DR;
      JTB_PAU_DR: nx = tms ? JTB_EX2_DR : JTB_PAU_DR;
      JTB_EX2_DR: nx = tms ? JTB_UPD_DR : JTB_SH_DR;
      JTB_UPD_DR: nx = tms ? JTB_SEL_DR : JTB_RTI;
      JTB_SEL_IR: nx = tms ? JTB_TLR : JTB_CAP_IR;
      JTB_CAP_IR: nx = tms ? JTB_EX1_IR : JTB_SH_IR;
      JTB_SH_IR:  nx = tms ? JTB_EX1_IR : JTB_SH_IR;
      JTB_EX1_IR: nx = tms ? JTB_UPD_IR : JTB_PAU_IR;
      JTB_PAU_IR: nx = tms ? JTB_EX2_IR : JTB_PAU_IR;
      JTB_EX2_IR: nx = tms ? JTB_UPD_IR : JTB_SH_IR;
      JTB_UPD_IR: nx = tms ? JTB_SEL_DR : JTB_RTI;
    endcase
    return nx;
  endfunction

  // all four pins cross into the system clock domain
  jtb_sync #(
    .W(`JTB_PINS),
    .RST(`JTB_PIN_IDLE)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_d(i_pin_in),
    .o_q(pin_s)
  );

  // synchronised pin levels by function
  assign tck_s = pin_s[`JTB_PIN_TCK];
  assign tms_s = pin_s[`JTB_PIN_TMS];
  assign tdi_s = pin_s[`JTB_PIN_TDI];

  // test clock edges, only while the pins serve the test port
  assign tck_rise = ~q.gpio & tck_s & ~q.tck_d;
  assign tck_fall = ~q.gpio & ~tck_s & q.tck_d;

  // identification only for its own code, everything else is bypass
  assign sel_id = (q.ir_act == `JTB_IR_IDCODE); // [R4] [R14]

  // shift states of the two paths
  assign sh_ir = (q.st == JTB_SH_IR);
  assign sh_dr = (q.st == JTB_SH_DR);

  // register strobes, all taken on a rising test clock edge
  assign ir_cap = tck_rise & (q.st == JTB_CAP_IR);
  assign ir_shift = tck_rise & sh_ir; // [R6]
  assign id_cap = tck_rise & (q.st == JTB_CAP_DR) & sel_id;
  assign id_shift = tck_rise & sh_dr & sel_id; // [R6]
  assign byp_cap = tck_rise & (q.st == JTB_CAP_DR) & ~sel_id;
  assign byp_shift = tck_rise & sh_dr & ~sel_id; // [R1] [R3] [R6]

  // instruction shift register, captures the fixed 0001 pattern
  jtb_shreg #(
    .W(`JTB_IR_W)
  ) u_ir_sr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cap(ir_cap),
    .i_shift(ir_shift),
    .i_cap_val(`JTB_IR_CAPTURE),
    .i_sin(tdi_s),
    .o_q(ir_sr)
  );

  // identification register, reloaded on each data capture while the identification instruction is active
  jtb_shreg #(
    .W(`JTB_ID_W)
  ) u_id_sr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cap(id_cap),
    .i_shift(id_shift),
    .i_cap_val(IDCODE),
    .i_sin(tdi_s),
    .o_q(id_sr)
  );

  // one-bit bypass register, captures zero
  jtb_shreg #(
    .W(`JTB_BYP_W)
  ) u_byp_sr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cap(byp_cap),
    .i_shift(byp_shift),
    .i_cap_val(`JTB_BYP_CAPTURE),
    .i_sin(tdi_s),
    .o_q(byp_sr)
  );

  // bit presented at the serial output
  always_comb
  begin
    if (sh_ir)
    begin
      tdo_bit = ir_sr[0];
    end
    else if (sel_id)
    begin
      tdo_bit = id_sr[0]; // [R4]
    end
    else
    begin
      tdo_bit = byp_sr[0]; // [R1]
    end
  end

  // next state of the whole port
  always_comb
  begin
    d = q;
    d.tck_d = tck_s;
    d.gpio = i_cfg_port_off; // [R10] [R12]
    d.usr_in = pin_s; // [R11]
    if (q.gpio)
    begin
      // pins handed to user logic, test logic parked in reset
      d.st = JTB_TLR; // [R12]
      d.ir_act = `JTB_IR_IDCODE;
      d.pin_out = i_usr_out; // [R12]
      d.pin_oe_n = i_usr_oe_n; // [R12]
    end
    else
    begin
      // test input pins are never driven by the port
      d.pin_out[`JTB_PIN_TCK] = 1'b0;
      d.pin_out[`JTB_PIN_TMS] = 1'b0;
      d.pin_out[`JTB_PIN_TDI] = 1'b0;
      d.pin_oe_n[`JTB_PIN_TCK] = 1'b1;
      d.pin_oe_n[`JTB_PIN_TMS] = 1'b1;
      d.pin_oe_n[`JTB_PIN_TDI] = 1'b1;
      if (tck_rise)
      begin
        d.st = tap_next(q.st, tms_s); // [R13]
      end
      if (tck_fall)
      begin
        // output changes only on the falling edge
        if (sh_ir || sh_dr)
        begin
          d.pin_out[`JTB_PIN_TDO] = tdo_bit; // [R7]
          d.pin_oe_n[`JTB_PIN_TDO] = 1'b0;
        end
        else
        begin
          d.pin_oe_n[`JTB_PIN_TDO] = 1'b1; // [R8]
        end
        // new instruction takes effect on the falling edge in update
        if (q.st == JTB_UPD_IR)
        begin
          d.ir_act = ir_sr; // [R2] [R13]
        end
        else if (q.st == JTB_TLR)
        begin
          d.ir_act = `JTB_IR_IDCODE;
        end
      end
      // test reset state always restores the default instruction
      // and releases the serial output left enabled by user logic
      if (q.st == JTB_TLR)
      begin
        d.ir_act = `JTB_IR_IDCODE;
        d.pin_oe_n[`JTB_PIN_TDO] = 1'b1; // [R8]
      end
    end
  end

  // single state register; power-up reset stands in for a test reset pin
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      q.st <= JTB_TLR; // [R5]
      q.ir_act <= `JTB_IR_IDCODE; // [R5]
      q.tck_d <= 1'b1;
      q.gpio <= 1'b0; // [R10]
      q.pin_out <= `JTB_PIN_OUT_RST;
      q.pin_oe_n <= `JTB_OE_ALL_OFF; // [R8]
      q.usr_in <= `JTB_PIN_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign o_pin_out = q.pin_out;
  assign o_pin_oe_n = q.pin_oe_n;
  assign o_usr_in = q.usr_in;
  assign o_port_gpio = q.gpio;
  assign o_tap_state = q.st;
  assign o_ir = q.ir_act;

endmodule

// ### tb/jtb_tap_assertions.sv
// concurrent checks on the test access port pins
`timescale 1ns/10ps
`include "jtb_map.svh"
module jtb_chk (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cfg_port_off,
  input wire jtb_pkg::jtb_pins_t i_pin_in,
  input wire jtb_pkg::jtb_pins_t o_pin_out,
  input wire jtb_pkg::jtb_pins_t o_pin_oe_n,
  input wire jtb_pkg::jtb_pins_t i_usr_out,
  input wire jtb_pkg::jtb_pins_t i_usr_oe_n,
  input wire jtb_pkg::jtb_pins_t o_usr_in,
  input wire logic o_port_gpio,
  input wire jtb_pkg::jtb_tap_t o_tap_state,
  input wire logic [`JTB_IR_W-1:0] o_ir
);
  import jtb_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // gpio mode for two samples
  sequence s_gpio_on;
    o_port_gpio && $past(o_port_gpio);
  endsequence
  // test mode for two samples
  sequence s_test_on;
    !o_port_gpio && !$past(o_port_gpio);
  endsequence
  sequence s_pins_steady;
    $stable(i_pin_in) [*5];
  endsequence
  a_reset_vals: assert property ($fell(i_srst) |-> o_tap_state == JTB_TLR
    && o_ir == `JTB_IR_IDCODE && o_pin_oe_n == `JTB_OE_ALL_OFF && !o_port_gpio)
    else $error("reset values wrong");
  a_gpio_flag: assert property (1'b1 |=> o_port_gpio == $past(i_cfg_port_off))
    else $error("gpio flag wrong");
  a_gpio_pads: assert property (s_gpio_on |=> o_pin_out == $past(i_usr_out)
    && o_pin_oe_n == $past(i_usr_oe_n))
    else $error("gpio pads wrong");
  a_gpio_idle: assert property (s_gpio_on |-> o_tap_state == JTB_TLR)
    else $error("controller active in gpio mode");
  a_test_pins: assert property (s_test_on |-> o_pin_oe_n[2:0] == 3'h7)
    else $error("test input pins driven");
  a_usr_follow: assert property (s_pins_steady |-> o_usr_in == i_pin_in)
    else $error("buried logic input wrong");
  a_tdo_shift: assert property (s_test_on ##0 !o_pin_oe_n[3] |-> o_tap_state inside
    {JTB_SH_DR, JTB_EX1_DR, JTB_SH_IR, JTB_EX1_IR})
    else $error("serial out driven outside shift");
  a_tdo_fall: assert property (s_test_on ##0 $changed(o_pin_out[3]) |->
    !i_pin_in[0] && !$past(i_pin_in[0], 2))
    else $error("serial out moved off falling edge");
  a_tlr_hold: assert property ((o_tap_state == JTB_TLR && i_pin_in[1]) [*5] |=>
    o_tap_state == JTB_TLR)
    else $error("reset state left with mode high");
endmodule

// ### tb/jtb_ctl_model.sv
// scan controller model driving test clock, mode and data pins
`timescale 1ns/10ps
module jtb_ctl_model (
  input wire logic i_mclk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // idle levels, mode held high
  initial
  begin
    o_tck = 1'b1; // pulled-up idle level, no false edge after reset
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  // one test clock period of 12 mclk, output taken just before the rise
  task automatic bit_io(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_mclk);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (6) @(posedge i_mclk);
    tdo = i_tdo;
    o_tck <= 1'b1;
    repeat (5) @(posedge i_mclk);
  endtask
endmodule

// ### tb/test_jtag_tap_bypass_idcode.sv
// bench for the test access port with a controller model on the pins
`timescale 1ns/10ps
`include "jtb_map.svh"
module test_jtag_tap_bypass_idcode;
  import jtb_pkg::*;
  typedef struct packed {logic [3:0] code; logic is_id;} jtb_row_t;
  localparam logic [31:0] IDV = 32'h1234_5677; // arbitrary value
  localparam logic [39:0] PAT = 40'h01_6C3A_95E3;
  localparam jtb_row_t ROWS [5] = '{'{4'h1, 1'b1}, '{4'hF, 1'b0}, '{4'h0, 1'b0},
    '{4'h5, 1'b0}, '{4'hA, 1'b0}};
  logic i_mclk;
  logic i_srst = 1'b1;
  logic i_cfg_port_off = 1'b0;
  jtb_pins_t i_usr_out = 4'hA;
  jtb_pins_t i_usr_oe_n = 4'h5;
  jtb_pins_t i_pin_in, o_pin_out, o_pin_oe_n, o_usr_in, ext;
  logic o_port_gpio, tck, tms, tdi;
  jtb_tap_t o_tap_state;
  logic [3:0] o_ir;
  int failures = 0;
  int total_checks = 0;
  // pad levels, released serial out pulled up
  assign ext = {1'b1, tdi, tms, tck};
  always_comb
    for (int k = 0; k < 4; k++)
      i_pin_in[k] = (o_pin_oe_n[k] === 1'b0) ? o_pin_out[k] : ext[k];
  jtb_tap #(.IDCODE(IDV)) dut (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_cfg_port_off(i_cfg_port_off), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .i_usr_out(i_usr_out), .i_usr_oe_n(i_usr_oe_n),
    .o_usr_in(o_usr_in), .o_port_gpio(o_port_gpio), .o_tap_state(o_tap_state), .o_ir(o_ir));
  jtb_ctl_model ctl (.i_mclk(i_mclk), .i_tdo(i_pin_in[3]), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi));
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one scan from idle through ir or dr path, n bits, back to idle
  task automatic scan(input logic ir, input logic [39:0] din, input int n,
    output logic [39:0] dout);
    logic t;
    dout = '0;
    ctl.bit_io(1'b1, 1'b0, t);
    if (ir)
      ctl.bit_io(1'b1, 1'b0, t);
    repeat (2) ctl.bit_io(1'b0, 1'b0, t);
    for (int k = 0; k < n; k++)
    begin
      ctl.bit_io(k == n - 1, din[k], t);
      dout[k] = t;
    end
    ctl.bit_io(1'b1, 1'b0, t);
    ctl.bit_io(1'b0, 1'b0, t);
  endtask
  // main sequence
  initial
  begin
    logic [39:0] d;
    logic t;
    repeat (20) @(posedge i_mclk);
    chk(40'({o_tap_state, o_ir, o_pin_oe_n, o_port_gpio, o_pin_out}), 40'h3E0);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    ctl.bit_io(1'b0, 1'b0, t);
    foreach (ROWS[r])
    begin
      scan(1'b1, {36'h0, ROWS[r].code}, 4, d);
      chk(d, 40'h1);
      chk(40'(o_ir), 40'(ROWS[r].code));
      scan(1'b0, PAT, 33, d);
      chk(d, ROWS[r].is_id ? 40'({PAT[0], IDV}) : 40'({PAT[31:0], 1'b0}));
      chk(40'(o_pin_oe_n[3]), 40'h1);
    end
    // switch to gpio in mid-scan
    ctl.bit_io(1'b1, 1'b0, t);
    repeat (2) ctl.bit_io(1'b0, 1'b0, t);
    i_cfg_port_off <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk(40'({o_tap_state, o_port_gpio, o_pin_out, o_pin_oe_n, o_usr_in}), 40'h1A5B);
    i_usr_out <= 4'h0;
    i_usr_oe_n <= 4'hE;
    repeat (8) @(posedge i_mclk);
    chk(40'({o_tap_state, o_pin_out, o_pin_oe_n, o_usr_in}), 40'hE8);
    i_cfg_port_off <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk(40'({o_port_gpio, o_pin_oe_n[2:0]}), 40'h7);
    ctl.bit_io(1'b0, 1'b0, t);
    scan(1'b0, PAT, 32, d);
    chk(d, 40'(IDV));
    wrap_up;
  end
  // hang guard
  initial
  begin
    #40us;
    failures++;
    wrap_up;
  end
endmodule
bind jtb_tap jtb_chk u_chk (.i_mclk(i_mclk), .i_srst(i_srst),
  .i_cfg_port_off(i_cfg_port_off), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe_n(o_pin_oe_n), .i_usr_out(i_usr_out), .i_usr_oe_n(i_usr_oe_n),
  .o_usr_in(o_usr_in), .o_port_gpio(o_port_gpio), .o_tap_state(o_tap_state), .o_ir(o_ir));
